// File: hw/cca_defines.vh
// Functional notes
// - Date and time count advances by itself
// - Calendar write loads value and starts clock
// - Read returns running date and time
// - Repeat: none, 1 to 256, or endless
// - Alarm period from half second to year
// - Alarm raises interrupt unless handler suppressed
// - Alarm flag clears once read
// - Alarm enable control gates alarm generation
`ifndef CCA_DEFINES_VH
`define CCA_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CCA_TIME_OFS     12'h000
`define CCA_DATE_OFS     12'h004
`define CCA_CTRL_OFS     12'h008
`define CCA_ALMCFG_OFS   12'h00C
`define CCA_STATUS_OFS   12'h010
`define CCA_MASK_OFS     12'h014
`define CCA_FLAG_OFS     12'h018
`define CCA_REMAIN_OFS   12'h01C

// ****************************************************************
// Field positions
// ****************************************************************
`define CCA_CTRL_RUN     0
`define CCA_CTRL_ALMEN   1
`define CCA_CTRL_SUPP    2
`define CCA_ST_ALARM     0
`define CCA_ST_WRAP      1

// ****************************************************************
// Alarm repeat modes and period codes
// ****************************************************************
`define CCA_REP_NONE     2'h0
`define CCA_REP_COUNT    2'h1
`define CCA_REP_ENDLESS  2'h2
`define CCA_P_500MS      4'h0
`define CCA_P_1S         4'h1
`define CCA_P_10S        4'h2
`define CCA_P_1MIN       4'h3
`define CCA_P_10MIN      4'h4
`define CCA_P_1H         4'h5
`define CCA_P_1D         4'h6
`define CCA_P_1W         4'h7
`define CCA_P_1MON       4'h8
`define CCA_P_1Y         4'h9

// ****************************************************************
// Timing and reset values
// ****************************************************************
`define CCA_CLK_HZ       10000000
`define CCA_HALF_SEC_MS  500
`define CCA_HALF_CYC     (`CCA_CLK_HZ / 1000 * `CCA_HALF_SEC_MS)
`define CCA_RESET_DATE   32'h00000101
`define CCA_RESET_ZERO   32'h00000000

`endif

// File: hw/cca_wrap_counter.v
`timescale 1ns/1ns
// ****************************************************************
// Wrapping counter digit with carry
// ****************************************************************
module cca_wrap_counter #(
    parameter       W     = 6,
    parameter [W-1:0] FIRST = {W{1'b0}}
) (
    input  wire         pclk,    // Clock
    input  wire         presetn, // Async reset, low
    input  wire         load,    // Load new value
    input  wire [W-1:0] load_val,// Value to load
    input  wire         inc,     // Step enable
    input  wire [W-1:0] last,    // Highest value before wrap
    output reg  [W-1:0] value,   // Current value
    output wire         carry    // Step wraps this cycle
);
    assign carry = inc && (value >= last);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            value <= FIRST;
        end else if (load) begin
            value <= load_val;
        end else if (carry) begin
            value <= FIRST;
        end else if (inc) begin
            value <= value + {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule

// File: hw/cca_top.v
`timescale 1ns/1ns
`include "cca_defines.vh"
module cca_top #(
    parameter [31:0] HALF_CYC = `CCA_HALF_CYC
) (
    input  wire        pclk,    // APB clock, 10 MHz
    input  wire        presetn, // Async reset, low
    input  wire        psel,    // APB select
    input  wire        penable, // APB enable
    input  wire        pwrite,  // APB direction
    input  wire [11:0] paddr,   // APB byte address
    input  wire [31:0] pwdata,  // APB write data
    output reg  [31:0] prdata,  // APB read data
    output wire        pready,  // APB ready
    output wire        pslverr, // APB error
    output wire        irq      // Level interrupt
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [31:0] half_cnt_reg;
    reg         half_reg;
    reg         run_reg;
    reg         almen_reg;
    reg         supp_reg;
    reg  [1:0]  rep_mode_reg;
    reg  [3:0]  period_reg;
    reg  [7:0]  rep_count_reg;
    reg  [8:0]  remain_reg;
    reg  [1:0]  status_reg;
    reg  [1:0]  mask_reg;
    reg         flag_reg;
    reg  [31:0] prdata_next;
    reg         fire;
    wire        wr = psel && penable && pwrite;
    wire        rd = psel && penable && !pwrite;
    wire        ld_time = wr && (paddr == `CCA_TIME_OFS);
    wire        ld_date = wr && (paddr == `CCA_DATE_OFS);
    wire        tick_half;
    wire        tick_sec;

    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // ****************************************************************
    // Half second divider
    // ****************************************************************
    assign tick_half = run_reg && (half_cnt_reg == HALF_CYC - 32'h1);
    assign tick_sec  = tick_half && half_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_cnt_reg <= 32'h0;
            half_reg     <= 1'b0;
        end else if (ld_time || !run_reg) begin
            half_cnt_reg <= 32'h0;
            half_reg     <= 1'b0;
        end else if (tick_half) begin
            half_cnt_reg <= 32'h0;
            half_reg     <= ~half_reg;
        end else begin
            half_cnt_reg <= half_cnt_reg + 32'h1;
        end
    end

    // ****************************************************************
    // Calendar digits
    // ****************************************************************
    wire [5:0] sec, min;
    wire [4:0] hour, day;
    wire [3:0] mon;
    wire [7:0] year;
    wire [2:0] wday;
    wire       c_sec, c_min, c_hour, c_day, c_mon, c_wday;
    reg  [4:0] mdays;
    wire       leap = (year[1:0] == 2'b00);

    always @* begin
        case (mon)
            4'h2:    mdays = leap ? 5'd29 : 5'd28;
            4'h4, 4'h6, 4'h9, 4'hB: mdays = 5'd30;
            default: mdays = 5'd31;
        endcase
    end

    // Time register: [5:0] sec, [13:8] min, [20:16] hour
    // Date register: [4:0] day, [11:8] month, [23:16] year, [26:24] weekday
    cca_wrap_counter #(.W(6), .FIRST(6'd0)) u_sec (
        .pclk(pclk), .presetn(presetn), .load(ld_time),
        .load_val(pwdata[5:0]), .inc(tick_sec), .last(6'd59),
        .value(sec), .carry(c_sec));
    cca_wrap_counter #(.W(6), .FIRST(6'd0)) u_min (
        .pclk(pclk), .presetn(presetn), .load(ld_time),
        .load_val(pwdata[13:8]), .inc(c_sec), .last(6'd59),
        .value(min), .carry(c_min));
    cca_wrap_counter #(.W(5), .FIRST(5'd0)) u_hour (
        .pclk(pclk), .presetn(presetn), .load(ld_time),
        .load_val(pwdata[20:16]), .inc(c_min), .last(5'd23),
        .value(hour), .carry(c_hour));
    cca_wrap_counter #(.W(5), .FIRST(5'd1)) u_day (
        .pclk(pclk), .presetn(presetn), .load(ld_date),
        .load_val(pwdata[4:0]), .inc(c_hour), .last(mdays),
        .value(day), .carry(c_day));
    cca_wrap_counter #(.W(4), .FIRST(4'd1)) u_mon (
        .pclk(pclk), .presetn(presetn), .load(ld_date),
        .load_val(pwdata[11:8]), .inc(c_day), .last(4'd12),
        .value(mon), .carry(c_mon));
    cca_wrap_counter #(.W(8), .FIRST(8'd0)) u_year (
        .pclk(pclk), .presetn(presetn), .load(ld_date),
        .load_val(pwdata[23:16]), .inc(c_mon), .last(8'd99),
        .value(year), .carry());
    cca_wrap_counter #(.W(3), .FIRST(3'd0)) u_wday (
        .pclk(pclk), .presetn(presetn), .load(ld_date),
        .load_val(pwdata[26:24]), .inc(c_hour), .last(3'd6),
        .value(wday), .carry(c_wday));

    // ****************************************************************
    // Alarm period events
    // ****************************************************************
    reg  ev;
    wire ten_s   = c_sec  ? 1'b0 : (tick_sec && (sec == 6'd9 || sec == 6'd19 ||
                   sec == 6'd29 || sec == 6'd39 || sec == 6'd49)) ;
    wire ten_min = c_min  ? 1'b0 : (c_sec && (min == 6'd9 || min == 6'd19 ||
                   min == 6'd29 || min == 6'd39 || min == 6'd49));

    always @* begin
        case (period_reg)
            `CCA_P_500MS: ev = tick_half;
            `CCA_P_1S:    ev = tick_sec;
            `CCA_P_10S:   ev = ten_s || c_sec;
            `CCA_P_1MIN:  ev = c_sec;
            `CCA_P_10MIN: ev = ten_min || c_min;
            `CCA_P_1H:    ev = c_min;
            `CCA_P_1D:    ev = c_hour;
            `CCA_P_1W:    ev = c_wday;
            `CCA_P_1MON:  ev = c_day;
            `CCA_P_1Y:    ev = c_mon;
            default:      ev = 1'b0;
        endcase
    end

    always @* begin
        fire = 1'b0;
        if (almen_reg && ev) begin
            if (rep_mode_reg == `CCA_REP_ENDLESS) begin
                fire = 1'b1;
            end else if (remain_reg != 9'd0) begin
                fire = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Register writes and alarm state
    // ****************************************************************
    wire rd_flag = rd && (paddr == `CCA_FLAG_OFS);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_reg       <= 1'b0;
            almen_reg     <= 1'b0;
            supp_reg      <= 1'b0;
            rep_mode_reg  <= `CCA_REP_NONE;
            period_reg    <= `CCA_P_1S;
            rep_count_reg <= 8'h0;
            remain_reg    <= 9'h0;
            status_reg    <= 2'h0;
            mask_reg      <= 2'h0;
            flag_reg      <= 1'b0;
        end else begin
            if (ld_time || ld_date) begin
                run_reg <= 1'b1;
            end
            // Count every shot outside endless mode, also when a register write lands in that cycle
            if (fire && rep_mode_reg != `CCA_REP_ENDLESS) begin
                remain_reg <= remain_reg - 9'd1;
            end
            if (wr && paddr == `CCA_CTRL_OFS) begin
                run_reg   <= pwdata[`CCA_CTRL_RUN];
                almen_reg <= pwdata[`CCA_CTRL_ALMEN];
                supp_reg  <= pwdata[`CCA_CTRL_SUPP];
                if (pwdata[`CCA_CTRL_ALMEN] && !almen_reg) begin
                    // Arming reloads the shot budget: one plus repeats
                    remain_reg <= (rep_mode_reg == `CCA_REP_COUNT) ?
                                  {1'b0, rep_count_reg} + 9'd2 : 9'd1;
                end
            end else if (wr && paddr == `CCA_ALMCFG_OFS) begin
                rep_mode_reg  <= pwdata[1:0];
                period_reg    <= pwdata[7:4];
                rep_count_reg <= pwdata[15:8]; // Repeat count minus one
            end
            if (wr && paddr == `CCA_MASK_OFS) begin
                mask_reg <= pwdata[1:0];
            end
            // Hardware set wins over write-one-to-clear
            status_reg <= (status_reg & ~((wr && paddr == `CCA_STATUS_OFS) ?
                           pwdata[1:0] : 2'b00)) |
                          {c_mon && (year == 8'd99), fire && !supp_reg};
            // Read consumes the flag, a new alarm in the same cycle wins
            if (fire) begin
                flag_reg <= 1'b1;
            end else if (rd_flag) begin
                flag_reg <= 1'b0;
            end
        end
    end

    assign irq = |(status_reg & mask_reg);

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always @* begin
        prdata_next = 32'h0;
        if (paddr == `CCA_TIME_OFS) begin
            prdata_next = {11'h0, hour, 2'h0, min, 2'h0, sec};
        end else if (paddr == `CCA_DATE_OFS) begin
            prdata_next = {5'h0, wday, year, 4'h0, mon, 3'h0, day};
        end else if (paddr == `CCA_CTRL_OFS) begin
            prdata_next = {29'h0, supp_reg, almen_reg, run_reg};
        end else if (paddr == `CCA_ALMCFG_OFS) begin
            prdata_next = {16'h0, rep_count_reg, period_reg, 2'h0, rep_mode_reg};
        end else if (paddr == `CCA_STATUS_OFS) begin
            prdata_next = {30'h0, status_reg};
        end else if (paddr == `CCA_MASK_OFS) begin
            prdata_next = {30'h0, mask_reg};
        end else if (paddr == `CCA_FLAG_OFS) begin
            prdata_next = {31'h0, flag_reg};
        end else if (paddr == `CCA_REMAIN_OFS) begin
            prdata_next = {23'h0, remain_reg};
        end
    end

    // Data is registered during setup so it stands in the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= prdata_next;
        end
    end
endmodule

// File: verif/cca_checker_sva.sv
`timescale 1ns/1ns
`include "cca_defines.vh"
module cca_checker (
    input wire logic        pclk,    // Clock
    input wire logic        presetn, // Reset
    input wire logic        psel,    // Select
    input wire logic        penable, // Enable
    input wire logic        pwrite,  // Write
    input wire logic [11:0] paddr,   // Address
    input wire logic [31:0] pwdata,  // Wdata
    input wire logic [31:0] prdata,  // Rdata
    input wire logic        pready,  // Ready
    input wire logic        pslverr, // Error
    input wire logic        irq      // Interrupt
);
    wire        acc = psel && penable;
    wire        rd  = acc && !pwrite;
    reg  [31:0] mask_reg;
    // Shadow of the mask register
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            mask_reg <= 32'h00000000;
        else if (acc && pwrite && paddr == `CCA_MASK_OFS)
            mask_reg <= pwdata;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ********
    // Checks
    // ********
    property p_ready; psel |-> pready; endproperty
    a_ready: assert property (p_ready)
        else $error("pready low in transfer");
    property p_no_err; acc |-> !pslverr; endproperty
    a_no_err: assert property (p_no_err)
        else $error("error response seen");
    property p_time;
        rd && paddr == `CCA_TIME_OFS |-> prdata[5:0] < 6'h3C && prdata[13:8] < 6'h3C
            && prdata[20:16] < 5'h18 && (prdata & 32'hFFE0C0C0) == 32'h00000000;
    endproperty
    a_time: assert property (p_time)
        else $error("time fields out of range");
    property p_date;
        rd && paddr == `CCA_DATE_OFS |-> prdata[4:0] != 5'h00 && prdata[11:8] != 4'h0
            && prdata[11:8] < 4'hD && (prdata & 32'hF800F0E0) == 32'h00000000;
    endproperty
    a_date: assert property (p_date)
        else $error("date fields out of range");
    property p_flag; rd && paddr == `CCA_FLAG_OFS |-> prdata[31:1] == 31'h00000000; endproperty
    a_flag: assert property (p_flag)
        else $error("flag word has stray bits");
    property p_unmap; rd && paddr >= 12'h020 |-> prdata == 32'h00000000; endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
    property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
    a_hold: assert property (p_hold)
        else $error("read data changed outside read setup");
    property p_irq_mask; irq |-> mask_reg != 32'h00000000; endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt with empty mask");
    property p_mask_off;
        acc && pwrite && paddr == `CCA_MASK_OFS && pwdata == 32'h00000000 |=> !irq;
    endproperty
    a_mask_off: assert property (p_mask_off)
        else $error("interrupt after mask cleared");
    c_flag: cover property (rd && paddr == `CCA_FLAG_OFS && prdata[0]);
    c_irq: cover property ($rose(irq));
    c_time: cover property (acc && pwrite && paddr == `CCA_TIME_OFS);
endmodule
bind cca_top cca_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// File: verif/calendar_clock_alarm_test.sv
`timescale 1ns/1ns
`include "cca_defines.vh"
module calendar_clock_alarm_test;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h00000000;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         irq;
    int          failures = 0;
    int          checks   = 0;
    logic [31:0] rd;
    logic        seen;
    cca_top #(.HALF_CYC(32'h00000004)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    always #50 pclk = ~pclk;
    task end_sim;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task wait_irq(input int lim);
        seen = 1'b0;
        for (int i = 0; i < lim && !seen; i++) begin
            @(negedge pclk);
            seen = (irq === 1'b1);
        end
    endtask
    // ********
    // Scenarios
    // ********
    task t_reset;
        apb(1'b0, `CCA_TIME_OFS, 32'h00000000); chk(rd, `CCA_RESET_ZERO);
        apb(1'b0, `CCA_DATE_OFS, 32'h00000000); chk(rd, `CCA_RESET_DATE);
        apb(1'b0, 12'h020, 32'h00000000); chk(rd, 32'h00000000);
        repeat (30) @(posedge pclk);
        apb(1'b0, `CCA_TIME_OFS, 32'h00000000); chk(rd, `CCA_RESET_ZERO);
    endtask
    task t_calendar;
        apb(1'b1, `CCA_DATE_OFS, 32'h03050C1F);
        apb(1'b1, `CCA_TIME_OFS, 32'h00173B3B);
        apb(1'b0, `CCA_DATE_OFS, 32'h00000000); chk(rd, 32'h03050C1F);
        for (int i = 0; i < 20 && rd === 32'h03050C1F; i++)
            apb(1'b0, `CCA_DATE_OFS, 32'h00000000);
        chk(rd, 32'h04060101);
        apb(1'b0, `CCA_TIME_OFS, 32'h00000000); chk(rd, 32'h00000000);
    endtask
    task t_suppress;
        apb(1'b1, `CCA_CTRL_OFS, 32'h00000001);
        apb(1'b1, `CCA_ALMCFG_OFS, 32'h00000002);
        apb(1'b1, `CCA_MASK_OFS, 32'h00000001);
        apb(1'b1, `CCA_CTRL_OFS, 32'h00000007);
        wait_irq(60); chk(seen, 1'b0);
        apb(1'b0, `CCA_STATUS_OFS, 32'h00000000); chk(rd[0], 1'b0);
        apb(1'b0, `CCA_FLAG_OFS, 32'h00000000); chk(rd, 32'h00000001);
        repeat (40) @(posedge pclk);
        apb(1'b0, `CCA_FLAG_OFS, 32'h00000000); chk(rd, 32'h00000001);
        apb(1'b1, `CCA_CTRL_OFS, 32'h00000001);
        apb(1'b0, `CCA_FLAG_OFS, 32'h00000000);
        repeat (40) @(posedge pclk);
        apb(1'b0, `CCA_FLAG_OFS, 32'h00000000); chk(rd, 32'h00000000);
    endtask
    task t_alarm(input logic [31:0] cfg, input logic [31:0] shots);
        time t_last;
        t_last = 0;
        apb(1'b1, `CCA_CTRL_OFS, 32'h00000001);
        apb(1'b1, `CCA_TIME_OFS, 32'h00000000);
        apb(1'b1, `CCA_MASK_OFS, 32'h00000001);
        apb(1'b1, `CCA_ALMCFG_OFS, cfg);
        apb(1'b1, `CCA_CTRL_OFS, 32'h00000003);
        apb(1'b0, `CCA_REMAIN_OFS, 32'h00000000); chk(rd, shots);
        for (int k = 0; k < shots; k++) begin
            wait_irq(300); chk(seen, 1'b1);
            if (k > 0) chk(32'($time - t_last), 32'h00001F40);
            t_last = $time;
            apb(1'b0, `CCA_FLAG_OFS, 32'h00000000); chk(rd, 32'h00000001);
            apb(1'b0, `CCA_FLAG_OFS, 32'h00000000); chk(rd, 32'h00000000);
            apb(1'b1, `CCA_MASK_OFS, 32'h00000000);
            @(negedge pclk); chk(irq, 1'b0);
            apb(1'b1, `CCA_MASK_OFS, 32'h00000001);
            apb(1'b1, `CCA_STATUS_OFS, 32'h00000001);
            @(negedge pclk); chk(irq, 1'b0);
        end
        apb(1'b0, `CCA_REMAIN_OFS, 32'h00000000); chk(rd, 32'h00000000);
        wait_irq(300); chk(seen, 1'b0);
    endtask
    // One-shot alarm two seconds before the boundary of the chosen period, one second before it for 1S
    task t_period(input logic [31:0] cfg, input logic [31:0] date,
                  input logic [31:0] tod, input int quiet);
        apb(1'b1, `CCA_CTRL_OFS, 32'h00000001);
        apb(1'b1, `CCA_MASK_OFS, 32'h00000001);
        apb(1'b1, `CCA_ALMCFG_OFS, cfg);
        apb(1'b1, `CCA_TIME_OFS, tod);
        apb(1'b1, `CCA_DATE_OFS, date);
        apb(1'b1, `CCA_CTRL_OFS, 32'h00000003);
        wait_irq(quiet); chk(seen, 1'b0);
        wait_irq(12); chk(seen, 1'b1);
        apb(1'b1, `CCA_STATUS_OFS, 32'h00000001);
        apb(1'b0, `CCA_FLAG_OFS, 32'h00000000); chk(rd, 32'h00000001);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_calendar;
        t_suppress;
        t_alarm(32'h00000020, 32'h00000001);
        t_alarm(32'h00000121, 32'h00000003);
        t_period(32'h00000010, 32'h00000101, 32'h0000003A, 1);
        t_period(32'h00000030, 32'h00000101, 32'h0000003A, 6);
        t_period(32'h00000040, 32'h00000101, 32'h0000093A, 6);
        t_period(32'h00000050, 32'h00000101, 32'h00003B3A, 6);
        t_period(32'h00000060, 32'h00000101, 32'h00173B3A, 6);
        t_period(32'h00000070, 32'h06000105, 32'h00173B3A, 6);
        t_period(32'h00000080, 32'h0000011F, 32'h00173B3A, 6);
        t_period(32'h00000090, 32'h00000C1F, 32'h00173B3A, 6);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        end_sim;
    end
    initial begin
        repeat (10000) @(posedge pclk);
        failures++;
        end_sim;
    end
endmodule
